// ==== src/uae_pkg.sv ====
// Constants, field layouts and carrier types for the USB address and
// event status register bank.
// Assumes an 8-bit register port with 16-bit addresses on one clock.
//
// What this block does
// - Address register reads 00h after any reset
// - Bus reset sets status bit 7
// - Bus reset resets engine, buffers, timer, suspend
// - Full-reset enable widens reset, drives reset pin
// - Suspend detection sets status bit 6
// - Resume detection sets status bit 5
// - Every host frame start sets status bit 4
// - Unlocked timer makes 1 ms pseudo frames, bit 3
// - Completed setup stage sets status bit 2
// - Setup buffer overwrite sets status bit 0
// - Flags read-only, cleared by vector register write
// - Bit 1 reads zero; all flags zero after reset
// - Flag interrupts only when mask bit set
package uae_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 16; // Register port address width
    localparam int DATA_W = 8; // Register port data width
    localparam logic [15:0] OFS_DEVICE_ADDRESS = 16'hFFFF; // Address reg
    localparam logic [15:0] OFS_EVENT_STATUS = 16'hFFFE; // Status flags
    localparam logic [15:0] OFS_INTERRUPT_MASK = 16'hFFFD; // Mask reg
    localparam logic [15:0] OFS_USB_CONTROL = 16'hFFFC; // Control reg
    localparam logic [15:0] OFS_INTERRUPT_VECTOR = 16'hFFB2; // Clear hook

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int ADDR_FIELD_W = 7; // Assigned address field width
    localparam logic [7:0] DEVICE_ADDRESS_RST = 8'h00; // Address default
    localparam logic [7:0] STATUS_RST = 8'h00; // Flags default
    localparam logic [7:0] MASK_RST = 8'h00; // Mask default
    localparam logic [7:0] CONTROL_RST = 8'h00; // Control default
    localparam logic [7:0] FLAG_VALID_BITS = 8'hFD; // Bit 1 reserved
    localparam int BIT_BUS_RESET = 7; // Bus reset flag
    localparam int BIT_SUSPEND = 6; // Suspend flag
    localparam int BIT_RESUME = 5; // Resume flag
    localparam int BIT_SOF = 4; // Host frame start flag
    localparam int BIT_PSEUDO_SOF = 3; // Pseudo frame flag
    localparam int BIT_SETUP = 2; // Setup complete flag
    localparam int BIT_OVERWRITE = 0; // Setup overwrite flag
    localparam int CTL_CONNECT = 7; // Connect bit
    localparam int CTL_FUNC_ENABLE = 6; // Function enable bit
    localparam int CTL_REMOTE_WAKE = 5; // Remote wake-up bit
    localparam int CTL_FULL_RESET_EN = 4; // Full reset enable bit
    localparam int CTL_ROM_SHADOW = 0; // ROM shadow bit
    localparam logic [7:0] CONTROL_VALID_BITS = 8'hF1; // Bits 3:1 reserved

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5; // 200 MHz system clock
    localparam int PSEUDO_SOF_PERIOD_NS = 1000000; // Nominal 1 ms
    localparam int PSEUDO_SOF_CYCLES = PSEUDO_SOF_PERIOD_NS / CLK_PERIOD_NS;
    localparam int PSEUDO_FRAME_FLAG_CNT_W = 18; // Counter width for 200000

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic busReset; // Host drives bus reset (level)
        logic suspend; // Suspend detected (pulse)
        logic resume; // Resume detected (pulse)
        logic sof; // Host frame start seen (pulse)
        logic setupDone; // Setup stage completed (pulse)
        logic setupOverwrite; // Setup buffer overwritten (pulse)
    } uae_bus_events_s;

    typedef struct packed {
        logic serialEngine; // Serial interface engine reset
        logic bufferManager; // Buffer manager reset
        logic frameTimer; // Frame timer reset
        logic suspendLogic; // Suspend and resume logic reset
        logic deviceLogic; // Remaining device logic reset
    } uae_block_resets_s;

endpackage : uae_pkg

// ==== src/uae_pseudo_frame.sv ====
// Pseudo frame-start generator for while the frame timer is unlocked.
// Assumes lock and restart inputs are synchronous to sys_clk.
module uae_pseudo_frame #(
    parameter int PERIOD = 200000,
    parameter int CNT_W = 18
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic restart,
    input wire logic locked,
    output logic pseudoPulse
);

    // ------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1); // Final count
    logic [CNT_W-1:0] count_ff; // Cycles since last frame start
    logic pulse_ff; // Registered pulse

    // Count only while unlocked; a real frame or lock restarts it
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            count_ff <= '0;
        end else if (restart || locked) begin
            count_ff <= '0;
        end else if (count_ff == LAST) begin
            count_ff <= '0;
        end else begin
            count_ff <= count_ff + 1'b1;
        end
    end

    // One pulse per elapsed period while unlocked
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pulse_ff <= 1'b0;
        end else begin
            pulse_ff <= !restart && !locked && (count_ff == LAST);
        end
    end

    assign pseudoPulse = pulse_ff;

endmodule : uae_pseudo_frame

// ==== src/uae_sticky_flags.sv ====
// Bank of sticky event flags with a gated interrupt summary.
// Assumes one-cycle set pulses and a one-cycle clear request.
module uae_sticky_flags #(
    parameter int WIDTH = 8,
    parameter logic [7:0] VALID = 8'hFF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] setPulse,
    input wire logic clearAll,
    input wire logic [WIDTH-1:0] maskBits,
    output logic [WIDTH-1:0] flags,
    output logic irqLevel
);

    // ------------------------------------------------------------
    // One flop per flag
    // ------------------------------------------------------------
    logic [WIDTH-1:0] flag_ff; // Held flags

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_flag
            if (VALID[gi]) begin : g_live
                // Set wins over the clear in the same cycle
                always_ff @(posedge sys_clk or posedge rst) begin
                    if (rst) begin
                        flag_ff[gi] <= 1'b0;
                    end else if (setPulse[gi]) begin
                        flag_ff[gi] <= 1'b1;
                    end else if (clearAll) begin
                        flag_ff[gi] <= 1'b0;
                    end
                end
            end else begin : g_resv
                assign flag_ff[gi] = 1'b0;
            end
        end
    endgenerate

    assign flags = flag_ff;
    // Masked summary, registered downstream
    assign irqLevel = |(flag_ff & maskBits);

endmodule : uae_sticky_flags

// ==== src/uae_usb_regs.sv ====
// Top of the USB address and event status register bank.
// Assumes a byte register port with one-cycle strobes and read data
// one cycle later, and bus event inputs synchronous to sys_clk.
module uae_usb_regs #(
    parameter int PSEUDO_FRAME_FLAG_CYCLES = uae_pkg::PSEUDO_SOF_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [uae_pkg::ADDR_W-1:0] regAddr,
    input wire logic [uae_pkg::DATA_W-1:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [uae_pkg::DATA_W-1:0] regReadData,
    input wire uae_pkg::uae_bus_events_s busEvents,
    input wire logic frameLocked,
    output logic [uae_pkg::ADDR_FIELD_W-1:0] deviceAddress,
    output logic connectBit,
    output logic functionEnable,
    output logic remoteWakeup,
    output logic romShadowBit,
    output uae_pkg::uae_block_resets_s blockResets,
    output logic resetOutputPin,
    output logic irq
);

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    logic hitAddress; // Device address register selected
    logic hitStatus; // Event status register selected
    logic hitMask; // Interrupt mask register selected
    logic hitControl; // USB control register selected
    logic hitVector; // Interrupt vector register selected

    assign hitAddress = (regAddr == uae_pkg::OFS_DEVICE_ADDRESS);
    assign hitStatus = (regAddr == uae_pkg::OFS_EVENT_STATUS);
    assign hitMask = (regAddr == uae_pkg::OFS_INTERRUPT_MASK);
    assign hitControl = (regAddr == uae_pkg::OFS_USB_CONTROL);
    assign hitVector = (regAddr == uae_pkg::OFS_INTERRUPT_VECTOR);

    // ------------------------------------------------------------
    // Bus reset detection
    // ------------------------------------------------------------
    logic busResetPrev_ff; // Bus reset level one cycle ago
    logic busResetRise; // First cycle of a bus reset
    logic fullResetActive; // Bus reset widened to all logic

    // Remember last level for edge detection
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busResetPrev_ff <= 1'b0;
        end else begin
            busResetPrev_ff <= busEvents.busReset;
        end
    end

    assign busResetRise = busEvents.busReset && !busResetPrev_ff;

    // ------------------------------------------------------------
    // USB control register
    // ------------------------------------------------------------
    logic [7:0] control_ff; // Control bits
    logic [7:0] nxt_control; // Next control bits

    assign fullResetActive = busEvents.busReset &&
        control_ff[uae_pkg::CTL_FULL_RESET_EN];

    // Next control value from writes and bus reset
    always_comb begin
        nxt_control = control_ff;
        if (regWrite && hitControl) begin
            nxt_control = regWriteData & uae_pkg::CONTROL_VALID_BITS;
        end
        if (busEvents.busReset) begin
            // Function enable always drops on bus reset
            nxt_control[uae_pkg::CTL_FUNC_ENABLE] = 1'b0;
        end
        if (fullResetActive) begin
            // Full reset spares connect, shadow and the enable itself
            nxt_control[uae_pkg::CTL_REMOTE_WAKE] = 1'b0;
        end
    end

    // Control register storage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            control_ff <= uae_pkg::CONTROL_RST;
        end else begin
            control_ff <= nxt_control;
        end
    end

    // ------------------------------------------------------------
    // Device address register
    // ------------------------------------------------------------
    logic [uae_pkg::ADDR_FIELD_W-1:0] address_ff; // Assigned address

    // Firmware writes bits 6:0; bus reset returns to zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            address_ff <= uae_pkg::DEVICE_ADDRESS_RST[6:0];
        end else if (busEvents.busReset) begin
            address_ff <= uae_pkg::DEVICE_ADDRESS_RST[6:0];
        end else if (regWrite && hitAddress) begin
            // Bit 7 is reserved and dropped
            address_ff <= regWriteData[6:0];
        end
    end

    // ------------------------------------------------------------
    // Interrupt mask register
    // ------------------------------------------------------------
    logic [7:0] mask_ff; // Interrupt enables per flag

    // Mask survives a plain bus reset, not a full one
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mask_ff <= uae_pkg::MASK_RST;
        end else if (fullResetActive) begin
            mask_ff <= uae_pkg::MASK_RST;
        end else if (regWrite && hitMask) begin
            mask_ff <= regWriteData & uae_pkg::FLAG_VALID_BITS;
        end
    end

    // ------------------------------------------------------------
    // Pseudo frame generator
    // ------------------------------------------------------------
    logic pseudoSof; // Artificial frame start pulse

    uae_pseudo_frame #(
        .PERIOD(PSEUDO_FRAME_FLAG_CYCLES),
        .CNT_W(uae_pkg::PSEUDO_FRAME_FLAG_CNT_W)
    ) u_pseudo_frame (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(busEvents.busReset || busEvents.sof),
        .locked(frameLocked),
        .pseudoPulse(pseudoSof)
    );

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------
    logic [7:0] setVector; // Set pulse per status bit
    logic [7:0] statusFlags; // Current status flags
    logic flagClear; // Clear request for all flags
    logic irqRaw; // Masked flag summary

    // Map bus events onto their status bits
    always_comb begin
        setVector = 8'h00;
        setVector[uae_pkg::BIT_BUS_RESET] = busResetRise;
        setVector[uae_pkg::BIT_SUSPEND] = busEvents.suspend;
        setVector[uae_pkg::BIT_RESUME] = busEvents.resume;
        setVector[uae_pkg::BIT_SOF] = busEvents.sof;
        setVector[uae_pkg::BIT_PSEUDO_SOF] = pseudoSof;
        setVector[uae_pkg::BIT_SETUP] = busEvents.setupDone;
        setVector[uae_pkg::BIT_OVERWRITE] = busEvents.setupOverwrite;
    end

    // Vector write clears; a status read also acknowledges
    assign flagClear = (regWrite && hitVector) ||
        (regRead && hitStatus);

    uae_sticky_flags #(
        .WIDTH(8),
        .VALID(uae_pkg::FLAG_VALID_BITS)
    ) u_sticky_flags (
        .sys_clk(sys_clk),
        .rst(rst),
        .setPulse(setVector),
        .clearAll(flagClear),
        .maskBits(mask_ff),
        .flags(statusFlags),
        .irqLevel(irqRaw)
    );

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    logic irq_ff; // Registered interrupt level

    // High while any unmasked flag is held
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= irqRaw;
        end
    end

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    logic [7:0] readData_ff; // Read data, one cycle after the strobe
    logic [7:0] nxt_readData; // Selected read value

    // Select read value; unmapped or write-only reads give zero
    always_comb begin
        nxt_readData = 8'h00;
        if (hitAddress) begin
            nxt_readData = {1'b0, address_ff};
        end else if (hitStatus) begin
            nxt_readData = statusFlags;
        end else if (hitMask) begin
            nxt_readData = mask_ff;
        end else if (hitControl) begin
            nxt_readData = control_ff;
        end
    end

    // Data stand only in the cycle after the read strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            readData_ff <= 8'h00;
        end else if (regRead) begin
            readData_ff <= nxt_readData;
        end else begin
            readData_ff <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Block resets and reset pin
    // ------------------------------------------------------------
    uae_pkg::uae_block_resets_s resets_ff; // Registered reset fan-out
    logic resetPin_ff; // Registered reset output pin

    // USB blocks always follow the bus reset level
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resets_ff <= '0;
        end else begin
            resets_ff.serialEngine <= busEvents.busReset;
            resets_ff.bufferManager <= busEvents.busReset;
            resets_ff.frameTimer <= busEvents.busReset;
            resets_ff.suspendLogic <= busEvents.busReset;
            resets_ff.deviceLogic <= fullResetActive;
        end
    end

    // Reset pin active only for a widened bus reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resetPin_ff <= 1'b0;
        end else begin
            resetPin_ff <= fullResetActive;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    logic [6:0] addrOut_ff; // Address as seen by the engine
    logic [3:0] ctlOut_ff; // Connect, enable, wake, shadow

    // Copy state to the pins through flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            addrOut_ff <= uae_pkg::DEVICE_ADDRESS_RST[6:0];
            ctlOut_ff <= 4'h0;
        end else begin
            addrOut_ff <= address_ff;
            ctlOut_ff <= {control_ff[uae_pkg::CTL_CONNECT],
                control_ff[uae_pkg::CTL_FUNC_ENABLE],
                control_ff[uae_pkg::CTL_REMOTE_WAKE],
                control_ff[uae_pkg::CTL_ROM_SHADOW]};
        end
    end

    assign regReadData = readData_ff;
    assign deviceAddress = addrOut_ff;
    assign connectBit = ctlOut_ff[3];
    assign functionEnable = ctlOut_ff[2];
    assign remoteWakeup = ctlOut_ff[1];
    assign romShadowBit = ctlOut_ff[0];
    assign blockResets = resets_ff;
    assign resetOutputPin = resetPin_ff;
    assign irq = irq_ff;

endmodule : uae_usb_regs

// ==== verif/uae_host_model.sv ====
// Far-side model: host bus events seen by the register bank.
// Assumes commands from the bench, synchronous to sys_clk.
module uae_host_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic evtGo,
    input wire logic [2:0] evtSel,
    input wire logic holdReset,
    output uae_pkg::uae_bus_events_s busEvents
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Event drive
    // ----------------------------------------
    // Pulses last one cycle; bus reset follows the hold level
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busEvents <= '0;
        end else begin
            busEvents <= '0;
            busEvents.busReset <= holdReset;
            if (evtGo) begin
                busEvents[evtSel] <= 1'b1;
            end
        end
    end
endmodule : uae_host_model

// ==== verif/uae_usb_regs_bench.sv ====
// Self-checking bench for the register bank.
// Assumes the host model and bound checker compile first.
module uae_usb_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PSEUDO_FRAME_FLAG = 20; // Shortened pseudo frame period
    int bitOf[5] = '{0, 2, 4, 5, 6}; // Status bit of each event
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] regAddr = '0;
    logic [7:0] regWriteData = '0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic frameLocked = 1'b1;
    logic evtGo = 1'b0;
    logic [2:0] evtSel = '0;
    logic holdReset = 1'b0;
    logic rdSeen = 1'b0;
    logic [7:0] regReadData;
    logic [6:0] deviceAddress;
    logic connectBit, functionEnable, remoteWakeup, romShadowBit;
    logic resetOutputPin;
    logic irq;
    uae_pkg::uae_bus_events_s busEvents;
    uae_pkg::uae_block_resets_s blockResets;
    logic [7:0] expQ[$]; // Expected read data, oldest first
    int badCount = 0;
    int totalChecks = 0;
    logic [31:0] seed = 32'h07FE;
    // ----------------------------------------
    // Clock, design and far side
    // ----------------------------------------
    always #2.5 sys_clk = ~sys_clk;
    uae_usb_regs #(.PSEUDO_FRAME_FLAG_CYCLES(PSEUDO_FRAME_FLAG)) u_uae_usb_regs (
        .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .regReadData(regReadData),
        .busEvents(busEvents), .frameLocked(frameLocked),
        .deviceAddress(deviceAddress), .connectBit(connectBit),
        .functionEnable(functionEnable), .remoteWakeup(remoteWakeup),
        .romShadowBit(romShadowBit),
        .blockResets(blockResets), .resetOutputPin(resetOutputPin),
        .irq(irq));
    uae_host_model u_uae_host_model (
        .sys_clk(sys_clk), .rst(rst), .evtGo(evtGo), .evtSel(evtSel),
        .holdReset(holdReset), .busEvents(busEvents));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            badCount++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask : wr
    // Read and note the expected data
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge sys_clk);
        regRead <= 1'b0;
    endtask : rd
    // One-cycle host event
    task automatic ev(input logic [2:0] s);
        @(posedge sys_clk);
        evtGo <= 1'b1;
        evtSel <= s;
        @(posedge sys_clk);
        evtGo <= 1'b0;
    endtask : ev
    task automatic reportAndStop;
        $display("Checks %0d, mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : reportAndStop
    // ----------------------------------------
    // Read data monitor
    // ----------------------------------------
    always @(posedge sys_clk) rdSeen <= regRead;
    always @(negedge sys_clk) begin
        if (rdSeen) begin
            check(regReadData, expQ.pop_front());
        end
    end
    // Watchdog
    initial begin
        #20000;
        badCount++;
        reportAndStop();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd(16'hFFFF, 8'h00);
        rd(16'hFFFE, 8'h00);
        rd(16'h1234, 8'h00);
        // Random addresses; status writes ignored
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(16'hFFFF, seed[7:0]);
            wr(16'hFFFE, seed[15:8]);
            rd(16'hFFFF, {1'b0, seed[6:0]});
            rd(16'hFFFE, 8'h00);
        end
        check({1'b0, deviceAddress}, {1'b0, seed[6:0]});
        // Each event with the mask open
        wr(16'hFFFD, 8'hFF);
        for (int i = 0; i < 5; i++) begin
            ev(i[2:0]);
            rd(16'hFFFE, 8'h01 << bitOf[i]);
            #1;
            check({7'h0, irq}, 8'h01);
            rd(16'hFFFE, 8'h00);
        end
        // Masked flag holds without interrupt
        wr(16'hFFFD, 8'h00);
        ev(3'd1);
        repeat (10) @(posedge sys_clk);
        #1;
        check({7'h0, irq}, 8'h00);
        wr(16'hFFFD, 8'h04);
        repeat (2) @(posedge sys_clk);
        #1;
        check({7'h0, irq}, 8'h01);
        wr(16'hFFB2, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1;
        check({7'h0, irq}, 8'h00);
        rd(16'hFFFE, 8'h00);
        // Pseudo frame while unlocked
        @(posedge sys_clk);
        frameLocked <= 1'b0;
        repeat (PSEUDO_FRAME_FLAG + 5) @(posedge sys_clk);
        frameLocked <= 1'b1;
        rd(16'hFFFE, 8'h08);
        // Bus reset, plain then with full reset enable
        for (int f = 0; f < 2; f++) begin
            wr(16'hFFFF, 8'h55);
            wr(16'hFFFC, f ? 8'hF1 : 8'hE1);
            @(posedge sys_clk);
            holdReset <= 1'b1;
            repeat (3) @(posedge sys_clk);
            #1;
            check({3'h0, blockResets}, {3'h0, 4'hF, f[0]});
            check({7'h0, resetOutputPin}, {7'h0, f[0]});
            @(posedge sys_clk);
            holdReset <= 1'b0;
            repeat (3) @(posedge sys_clk);
            rd(16'hFFFF, 8'h00);
            rd(16'hFFFE, 8'h80);
            rd(16'hFFFC, f ? 8'h91 : 8'hA1);
            check({4'h0, connectBit, functionEnable, remoteWakeup,
                romShadowBit}, f ? 8'h09 : 8'h0B);
        end
        repeat (3) @(posedge sys_clk);
        reportAndStop();
    end
endmodule : uae_usb_regs_bench

// ==== verif/uae_usb_regs_props.sv ====
// Port checks for the register bank.
// Assumes one clock and the async active-high reset.
module uae_usb_regs_props #(
    parameter int PSEUDO_FRAME_FLAG_CYCLES = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regReadData,
    input wire uae_pkg::uae_bus_events_s busEvents,
    input wire logic frameLocked,
    input wire logic [6:0] deviceAddress,
    input wire uae_pkg::uae_block_resets_s blockResets,
    input wire logic resetOutputPin,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    logic adRd; // Address register read
    logic adWr; // Address register write
    logic stRd; // Status register read
    logic vecWr; // Vector register write
    assign adRd = regRead && regAddr == uae_pkg::OFS_DEVICE_ADDRESS;
    assign adWr = regWrite && regAddr == uae_pkg::OFS_DEVICE_ADDRESS;
    assign stRd = regRead && regAddr == uae_pkg::OFS_EVENT_STATUS;
    assign vecWr = regWrite && regAddr == uae_pkg::OFS_INTERRUPT_VECTOR;
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Event pulse then status read shows the bit
    property flagSeen(ev, b);
        ev ##1 stRd |=> regReadData[b];
    endproperty
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    addr_msb_a: assert property (adRd |=> !regReadData[7])
        else $error("Address bit 7 read back set");
    stat_rsvd_a: assert property (stRd |=> !regReadData[1])
        else $error("Status bit 1 read back set");
    addr_load_a: assert property (
        adWr && !busEvents.busReset ##1 !adWr && !busEvents.busReset
        |=> deviceAddress == 7'($past(regWriteData, 2)))
        else $error("Device address not loaded");
    busrst_addr_a: assert property (
        busEvents.busReset [*3] |-> deviceAddress == 7'h00)
        else $error("Bus reset left the address");
    blk_rst_a: assert property (
        $rose(busEvents.busReset) |=> blockResets[4:1] == 4'hF)
        else $error("Block resets missing");
    full_rst_a: assert property (
        resetOutputPin |-> $past(busEvents.busReset)
        && blockResets.deviceLogic)
        else $error("Reset pin without bus reset");
    susp_flag_a: assert property (flagSeen(busEvents.suspend, 6))
        else $error("Suspend flag missing");
    res_flag_a: assert property (flagSeen(busEvents.resume, 5))
        else $error("Resume flag missing");
    sof_flag_a: assert property (flagSeen(busEvents.sof, 4))
        else $error("Frame start flag missing");
    setup_flag_a: assert property (flagSeen(busEvents.setupDone, 2))
        else $error("Setup flag missing");
    ovw_flag_a: assert property (
        flagSeen(busEvents.setupOverwrite, 0))
        else $error("Overwrite flag missing");
    irq_clr_a: assert property (
        vecWr && busEvents == '0 && frameLocked ##1 busEvents == '0
        |=> !irq)
        else $error("Interrupt survives vector write");
    cover property (resetOutputPin);
    cover property (irq);
    cover property (stRd ##1 regReadData[3]);
endmodule : uae_usb_regs_props

bind uae_usb_regs uae_usb_regs_props #(.PSEUDO_FRAME_FLAG_CYCLES(PSEUDO_FRAME_FLAG_CYCLES)) u_props (
    .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .busEvents(busEvents),
    .frameLocked(frameLocked), .deviceAddress(deviceAddress),
    .blockResets(blockResets), .resetOutputPin(resetOutputPin), .irq(irq));
